/* File: dv/bus_master_model.sv */
// Request source standing in for the serial bus master.
// One request per call, held one cycle, then released.
`timescale 1ns/1ps
module bus_master_model (
   input  wire logic             ref_clk_i,
   output fan_cfg_pkg::reg_req_t req_o
);
   import fan_cfg_pkg::*;
   initial req_o = '0;
   task automatic send(input logic [7:0] st, input logic w, input logic r, input logic [7:0] x, input logic [15:0] d);
      if (w && x == REG_MODE && d inside {[16'h4:16'h6]}) d = 16'h0000;
      if (w && x == REG_SKIP_END && d > RST_SKIP) d = RST_SKIP;
      @(posedge ref_clk_i);
      req_o <= {1'b1, st, w, r, x, d};
      @(posedge ref_clk_i);
      // Released lines carry the inverted values of the last request
      req_o <= {1'b0, ~st, ~w, ~r, ~x, ~d};
   endtask
endmodule // bus_master_model

/* File: dv/fan_cfg_bank_props.sv */
// Port checker of the fan config bank.
// Bound to every bank instance below.
`timescale 1ns/1ps
module fan_cfg_bank_props (
   input wire logic                   ref_clk_i,
   input wire logic                   rstn_i,
   input wire fan_cfg_pkg::reg_req_t  req_i,
   input wire fan_cfg_pkg::reg_rsp_t  rsp_o,
   input wire logic                   fan_stop_o,
   input wire logic                   restart_o,
   input wire logic [15:0]            power_limit_o,
   input wire logic [3:0]             mode_o,
   input wire fan_cfg_pkg::link_cfg_t link_cfg_o
);
   import fan_cfg_pkg::*;
   default clocking dc @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   wire tk = req_i.frame_ok && (req_i.wr || req_i.rd) && req_i.station == link_cfg_o.station;
   wire wr = tk && req_i.wr;
   wire rs = wr && req_i.index == REG_RESTART && req_i.wdata == RESTART_CMD;
   a_taken_acked: assert property (tk |=> rsp_o.ack) else $error("no ack");
   a_foreign_quiet: assert property (!tk |=> !rsp_o.ack) else $error("stray ack");
   a_polarity_range: assert property (wr && req_i.index == REG_POLARITY && req_i.wdata > 16'h0001 |=> rsp_o.exc)
      else $error("polarity kept");
   a_mode_legal: assert property (mode_o <= 4'hc) else $error("mode");
   a_power_bound: assert property (power_limit_o >= MIN_POWER && power_limit_o <= MAX_POWER)
      else $error("power");
   a_temp_hidden: assert property (tk && !req_i.wr && req_i.index == REG_TEMP_SET |=> rsp_o.exc && rsp_o.rdata == 16'h0000)
      else $error("temp read");
   a_restart_pulse: assert property (rs |-> ##[1:2] restart_o) else $error("restart");
   a_trip_holds: assert property (fan_stop_o && !rs && !$past(rs) && !$past(rs, 2) |=> fan_stop_o)
      else $error("trip lost");
   c_write: cover property (wr);
   c_trip: cover property ($rose(fan_stop_o));
   c_refuse: cover property (rsp_o.exc);
endmodule // fan_cfg_bank_props

bind fan_cfg_bank fan_cfg_bank_props props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req_i), .rsp_o(rsp_o),
   .fan_stop_o(fan_stop_o), .restart_o(restart_o), .power_limit_o(power_limit_o), .mode_o(mode_o),
   .link_cfg_o(link_cfg_o));

/* File: dv/tb.sv */
// Self-checking bench of the fan config bank.
// Requests go through the master model; watchdog second shortened.
`timescale 1ns/1ps
module tb;
   import fan_cfg_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [15:0] src [9];
   logic        al, ta, stop, wal, dout, cst;
   reg_req_t    req;
   reg_rsp_t    rsp;
   logic [15:0] tgt, pwr;
   logic [3:0]  mode;
   loop_cfg_t   lcfg;
   link_cfg_t   link;
   logic [16:0] q [$];
   logic [7:0]  lx [10] = '{8'h1f, 8'h24, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h32, 8'h33, 8'h34, 8'h36};
   logic [15:0] lg [10] = '{16'h1, 16'ha, 16'hf7, 16'h3, 16'h60, 16'h2, 16'h64, 16'h0, 16'h7fff, 16'h7fff};
   logic [15:0] lb [10] = '{16'h2, 16'h9, 16'hf8, 16'h4, 16'h61, 16'h3, 16'h65, 16'h8000, 16'h8000, 16'h8000};
   int          num_errors = 0;
   int          n_tests = 0;
   int          seed = 81;
   int          i, k;
   always #2.5 ref_clk_i = ~ref_clk_i;
   bus_master_model m (.ref_clk_i(ref_clk_i), .req_o(req));
   fan_cfg_bank #(.SEC_CYCLES(10)) dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req), .rsp_o(rsp),
      .analog_speed_i(src[0]), .fixed_speed_i(src[1]), .emul_fixed_i(src[2]), .follower_speed_i(src[3]),
      .loop_speed_i(src[4]), .analog_ref_i(src[5]), .max_speed_i(src[6]), .measured_speed_i(src[7]),
      .speed_low_i(src[8]), .alarm_i(al), .tacho_pwm_i(ta), .speed_target_o(tgt), .coast_o(cst), .fan_stop_o(stop),
      .watchdog_alarm_o(wal), .restart_o(), .power_limit_o(pwr), .mode_o(mode), .loop_cfg_o(lcfg),
      .link_cfg_o(link), .digital_out_o(dout));
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] x, input logic [15:0] d, input logic e);
      q.push_back({e, w ? 16'h0000 : d});
      m.send(8'h01, w, !w, x, d);
   endtask
   task automatic summarize();
      chk(q.size(), 0);
      $display("tests=%0d errors=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [15:0] rv(input logic [7:0] x);
      return x inside {8'h20, 8'h21} ? RST_SKIP : x == 8'h24 ? RST_POWER : x == 8'h2d ? RST_STATION :
         x == 8'h2f ? RST_BIT_RATE : 16'h0000;
   endfunction
   // Response monitor: oldest note against each ack
   always @(posedge ref_clk_i)
      if (rsp.ack === 1'b1) chk({rsp.exc, rsp.rdata}, q.size() ? q.pop_front() : 17'h1ffff);
   initial begin
      lg[7] = 16'($random(seed)) & 16'h7fff;
      repeat (2) @(posedge ref_clk_i);
      for (i = 0; i < 9; i++) src[i] <= 16'($random(seed)) & 16'h3fff | 16'h0002;
      k = $random(seed);
      al <= k[0];
      ta <= ~k[0];
      rstn_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      for (i = 8'h1f; i <= 8'h38; i++)
         if (i != 8'h23) acc(0, i[7:0], rv(i[7:0]), i inside {[8'h25:8'h2c], 8'h31});
      for (i = 0; i < 10; i++) begin
         acc(1, lx[i], lg[i], 0);
         acc(1, lx[i], lb[i], 1);
         acc(0, lx[i], lg[i], 0);
      end
      m.send(8'hf7, 1'b0, 1'b1, REG_KP, 16'h0000);
      chk({pwr, link, lcfg.invert, lcfg.kp}, {16'h000a, 8'h01, 16'h0060, 2'h0, 1'b1, lg[7]});
      for (i = 0; i < 14; i++) begin
         acc(1, REG_MODE, 16'(i), i > 12);
         repeat (2) @(posedge ref_clk_i);
         chk(mode, i > 12 ? 4'hc : i inside {[4:6]} ? 4'h0 : 4'(i));
         chk(lcfg.enable, i >= 10);
         chk(lcfg.reference, i == 10 ? src[5] : i >= 12 ? 16'h0064 : 16'h0000);
      end
      acc(1, REG_TEMP_SET, 16'h0456, 0);
      acc(0, REG_TEMP_SET, 16'h0000, 1);
      for (i = 0; i < 3; i++) begin
         acc(1, REG_MODE, 16'(i + (i > 0)), 0);
         repeat (2) @(posedge ref_clk_i);
         chk(tgt, i == 0 ? 16'h0456 : src[2 * i - 1]);
      end
      acc(1, REG_SKIP_START, src[1] - 16'h1, 0);
      acc(1, REG_SKIP_END, src[1] + 16'h3, 0);
      acc(1, REG_MODE, 16'h0002, 0);
      repeat (2) @(posedge ref_clk_i);
      chk(tgt, src[1] - 16'h1);
      acc(1, REG_SPEED_HIGH, 16'h0001, 0);
      for (i = 0; i < 4; i++) begin
         acc(1, REG_DOUT_FUNC, 16'(i), 0);
         repeat (2) @(posedge ref_clk_i);
         chk(dout, i == 0 ? ta : i == 1 ? al : i == 2);
      end
      acc(1, REG_COAST_SPEED, 16'h0001, 0);
      acc(1, REG_TEMP_SET, 16'h0000, 0);
      acc(1, REG_MODE, 16'h0000, 0);
      repeat (2) @(posedge ref_clk_i);
      chk({cst, tgt}, {1'b0, 16'h0001});
      src[7] <= 16'h0000;
      repeat (2) @(posedge ref_clk_i);
      chk({cst, tgt}, {1'b1, 16'h0000});
      chk(stop, 0);
      acc(1, REG_WATCHDOG, 16'h0002, 0);
      for (i = 0; i < 12; i++) acc(0, REG_WATCHDOG, 16'h0002, 0);
      chk(stop, 0);
      for (k = 0; k < 100 && stop !== 1'b1; k++) @(posedge ref_clk_i);
      chk({stop, wal, tgt}, {2'b11, 16'h0000});
      if (k == 100) summarize();
      acc(1, REG_RESTART, RESTART_CMD, 0);
      acc(0, REG_RESTART, 16'h0000, 0);
      repeat (2) @(posedge ref_clk_i);
      chk(stop, 0);
      summarize();
   end
endmodule // tb

/* File: hw/fan_cfg_bank.sv */
// Configuration holding-register bank of a fan drive, with setpoint selection,
// skip band, coast stop, digital output function and link silence watchdog.
// Assumes a frame decoder on the same clock delivering one request per cycle.
`timescale 1ns/1ps
module fan_cfg_bank #(
   parameter int unsigned SEC_CYCLES = fan_cfg_pkg::SEC_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic                   ref_clk_i,
   input  wire logic                   rstn_i,
   // Register access from frame decoder
   input  wire fan_cfg_pkg::reg_req_t  req_i,
   output fan_cfg_pkg::reg_rsp_t       rsp_o,
   // Drive state
   input  wire logic [15:0]            analog_speed_i,
   input  wire logic [15:0]            fixed_speed_i,
   input  wire logic [15:0]            emul_fixed_i,
   input  wire logic [15:0]            follower_speed_i,
   input  wire logic [15:0]            loop_speed_i,
   input  wire logic [15:0]            analog_ref_i,
   input  wire logic [15:0]            max_speed_i,
   input  wire logic [15:0]            measured_speed_i,
   input  wire logic [15:0]            speed_low_i,
   input  wire logic                   alarm_i,
   input  wire logic                   tacho_pwm_i,
   // Drive commands
   output logic [15:0]                 speed_target_o,
   output logic                        coast_o,
   output logic                        fan_stop_o,
   output logic                        watchdog_alarm_o,
   output logic                        restart_o,
   output logic [15:0]                 power_limit_o,
   output logic [3:0]                  mode_o,
   output fan_cfg_pkg::loop_cfg_t      loop_cfg_o,
   output fan_cfg_pkg::link_cfg_t      link_cfg_o,
   output logic                        digital_out_o
);
   import fan_cfg_pkg::*;

   logic [15:0] polarity_r;
   logic [15:0] skip_start_r;
   logic [15:0] skip_end_r;
   logic [15:0] mode_r;
   logic [15:0] coast_speed_r;
   logic [15:0] power_r;
   logic [15:0] station_r;
   logic [15:0] dout_func_r;
   logic [15:0] bit_rate_r;
   logic [15:0] framing_r;
   logic [15:0] loop_ref_r;
   logic [15:0] kp_r;
   logic [15:0] ki_r;
   logic [15:0] kd_r;
   logic [15:0] period_r;
   logic [15:0] speed_high_r;
   logic [15:0] watchdog_r;
   logic [15:0] temp_set_r;
   logic [7:0]  active_station_r;
   logic [1:0]  active_framing_r;
   logic        boot_done_r;
   logic        for_me;
   logic        wr_ok;
   logic        value_ok;
   logic        mapped;
   logic [15:0] rd_val;
   logic        restart_cmd;

   // Address match against the station latched at start-up
   assign for_me = req_i.frame_ok && (req_i.station == active_station_r);

   // Value checks; out-of-range writes are refused with an exception
   always_comb begin
      mapped   = 1'b1;
      value_ok = 1'b1;
      case (req_i.index)
         REG_RESTART:     value_ok = 1'b1;
         REG_POLARITY:    value_ok = req_i.wdata <= MAX_POLARITY;
         REG_SKIP_START:  value_ok = 1'b1;
         REG_SKIP_END:    value_ok = 1'b1;
         REG_MODE:        value_ok = req_i.wdata <= MAX_MODE;
         REG_COAST_SPEED: value_ok = 1'b1;
         REG_POWER_LIMIT: value_ok = (req_i.wdata >= MIN_POWER) && (req_i.wdata <= MAX_POWER);
         REG_STATION:     value_ok = (req_i.wdata >= MIN_STATION) && (req_i.wdata <= MAX_STATION);
         REG_DOUT_FUNC:   value_ok = req_i.wdata <= MAX_DOUT_FUNC;
         REG_BIT_RATE:    value_ok = (req_i.wdata == BIT_RATE_9K6) || (req_i.wdata == BIT_RATE_19K2);
         REG_FRAMING:     value_ok = req_i.wdata <= MAX_FRAMING;
         REG_LOOP_REF:    value_ok = req_i.wdata <= MAX_LOOP_REF;
         REG_KP:          value_ok = req_i.wdata <= MAX_GAIN;
         REG_KI:          value_ok = req_i.wdata <= MAX_GAIN;
         REG_KD:          value_ok = req_i.wdata <= MAX_GAIN;
         REG_PERIOD:      value_ok = req_i.wdata <= MAX_GAIN;
         REG_SPEED_HIGH:  value_ok = 1'b1;
         REG_WATCHDOG:    value_ok = 1'b1;
         REG_TEMP_SET:    value_ok = 1'b1;
         default: begin
            mapped   = 1'b0;
            value_ok = 1'b0;
         end
      endcase
   end

   assign wr_ok       = for_me && req_i.wr && value_ok;
   assign restart_cmd = wr_ok && (req_i.index == REG_RESTART) && (req_i.wdata == RESTART_CMD);

   // Holding registers
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         polarity_r    <= RST_ZERO;
         skip_start_r  <= RST_SKIP;
         skip_end_r    <= RST_SKIP;
         mode_r        <= RST_ZERO;
         coast_speed_r <= RST_ZERO;
         power_r       <= RST_POWER;
         station_r     <= RST_STATION;
         dout_func_r   <= RST_ZERO;
         bit_rate_r    <= RST_BIT_RATE;
         framing_r     <= RST_ZERO;
         loop_ref_r    <= RST_ZERO;
         kp_r          <= RST_ZERO;
         ki_r          <= RST_ZERO;
         kd_r          <= RST_ZERO;
         period_r      <= RST_ZERO;
         speed_high_r  <= RST_ZERO;
         watchdog_r    <= RST_ZERO;
         temp_set_r    <= RST_ZERO;
      end else if (wr_ok) begin
         case (req_i.index)
            REG_POLARITY:    polarity_r    <= req_i.wdata;
            REG_SKIP_START:  skip_start_r  <= req_i.wdata;
            REG_SKIP_END:    skip_end_r    <= req_i.wdata;
            REG_MODE:        mode_r        <= req_i.wdata;
            REG_COAST_SPEED: coast_speed_r <= req_i.wdata;
            REG_POWER_LIMIT: power_r       <= req_i.wdata;
            REG_STATION:     station_r     <= req_i.wdata;
            REG_DOUT_FUNC:   dout_func_r   <= req_i.wdata;
            REG_BIT_RATE:    bit_rate_r    <= req_i.wdata;
            REG_FRAMING:     framing_r     <= req_i.wdata;
            REG_LOOP_REF:    loop_ref_r    <= req_i.wdata;
            REG_KP:          kp_r          <= req_i.wdata;
            REG_KI:          ki_r          <= req_i.wdata;
            REG_KD:          kd_r          <= req_i.wdata;
            REG_PERIOD:      period_r      <= req_i.wdata;
            REG_SPEED_HIGH:  speed_high_r  <= req_i.wdata;
            REG_WATCHDOG:    watchdog_r    <= req_i.wdata;
            REG_TEMP_SET:    temp_set_r    <= req_i.wdata;
            default:         temp_set_r    <= temp_set_r;
         endcase
      end
   end

   // Address and framing latched once after reset release
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         boot_done_r      <= 1'b0;
         active_station_r <= RST_STATION[7:0];
         active_framing_r <= RST_ZERO[1:0];
      end else if (!boot_done_r) begin
         boot_done_r      <= 1'b1;
         active_station_r <= station_r[7:0];
         active_framing_r <= framing_r[1:0];
      end
   end

   // Read mux; restart register reads 0, temporary setpoint is not readable
   always_comb begin
      case (req_i.index)
         REG_RESTART:     rd_val = RST_ZERO;
         REG_POLARITY:    rd_val = polarity_r;
         REG_SKIP_START:  rd_val = skip_start_r;
         REG_SKIP_END:    rd_val = skip_end_r;
         REG_MODE:        rd_val = mode_r;
         REG_COAST_SPEED: rd_val = coast_speed_r;
         REG_POWER_LIMIT: rd_val = power_r;
         REG_STATION:     rd_val = station_r;
         REG_DOUT_FUNC:   rd_val = dout_func_r;
         REG_BIT_RATE:    rd_val = bit_rate_r;
         REG_FRAMING:     rd_val = framing_r;
         REG_LOOP_REF:    rd_val = loop_ref_r;
         REG_KP:          rd_val = kp_r;
         REG_KI:          rd_val = ki_r;
         REG_KD:          rd_val = kd_r;
         REG_PERIOD:      rd_val = period_r;
         REG_SPEED_HIGH:  rd_val = speed_high_r;
         REG_WATCHDOG:    rd_val = watchdog_r;
         default:         rd_val = RST_ZERO;
      endcase
   end

   // Answer one cycle after the request
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rsp_o <= '0;
      end else begin
         rsp_o.ack   <= for_me && (req_i.wr || req_i.rd);
         rsp_o.exc   <= for_me && ((req_i.wr && !value_ok) ||
                        (req_i.rd && (!mapped || req_i.index == REG_TEMP_SET)));
         rsp_o.rdata <= (for_me && req_i.rd) ? rd_val : RST_ZERO;
      end
   end

   // Link silence watchdog
   logic [31:0] tick_cnt_r;
   logic [15:0] sec_cnt_r;
   logic        wd_trip_r;
   logic        wd_expire;

   assign wd_expire = (watchdog_r != RST_ZERO) && (sec_cnt_r >= watchdog_r) && !for_me;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_cnt_r <= '0;
         sec_cnt_r  <= '0;
      end else if (for_me || watchdog_r == RST_ZERO || wd_trip_r) begin
         tick_cnt_r <= '0;
         sec_cnt_r  <= '0;
      end else if (tick_cnt_r == SEC_CYCLES - 1) begin
         tick_cnt_r <= '0;
         sec_cnt_r  <= sec_cnt_r + 16'h0001;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      end
   end

   // Trip holds until restart; a trip in the restart cycle wins
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wd_trip_r <= 1'b0;
      end else if (wd_expire) begin
         wd_trip_r <= 1'b1;
      end else if (restart_cmd) begin
         wd_trip_r <= 1'b0;
      end
   end

   // Setpoint selection by operating mode
   logic [15:0] setpoint;
   logic        loop_on;
   logic [15:0] loop_ref;

   always_comb begin
      setpoint = RST_ZERO;
      loop_on  = 1'b0;
      loop_ref = RST_ZERO;
      case (mode_r[3:0])
         MODE_BUS_SPEED: setpoint = temp_set_r;
         MODE_ANA_SPEED: setpoint = analog_speed_i;
         MODE_FIX_SPEED: setpoint = fixed_speed_i;
         MODE_FOLLOWER:  setpoint = follower_speed_i;
         MODE_ANA_AIR:   setpoint = RST_ZERO;
         MODE_TMP_AIR:   setpoint = RST_ZERO;
         MODE_FIX_AIR:   setpoint = RST_ZERO;
         MODE_ANA_EMUL:  setpoint = analog_speed_i;
         MODE_TMP_EMUL:  setpoint = temp_set_r;
         MODE_FIX_EMUL:  setpoint = emul_fixed_i;
         MODE_LOOP_ANA: begin
            loop_on  = 1'b1;
            loop_ref = analog_ref_i;
            setpoint = loop_speed_i;
         end
         MODE_LOOP_TMP: begin
            loop_on  = 1'b1;
            loop_ref = temp_set_r;
            setpoint = loop_speed_i;
         end
         MODE_LOOP_FIX: begin
            loop_on  = 1'b1;
            loop_ref = loop_ref_r;
            setpoint = loop_speed_i;
         end
         default: setpoint = RST_ZERO;
      endcase
   end

   // Skip band: move inner speeds to the nearer edge
   logic [15:0] skipped;

   always_comb begin
      skipped = setpoint;
      if (setpoint > skip_start_r && setpoint < skip_end_r) begin
         if ((setpoint - skip_start_r) < (skip_end_r - setpoint)) begin
            skipped = skip_start_r;
         end else begin
            skipped = skip_end_r;
         end
      end
   end

   // Stop sequence
   stop_state_t state_r;
   stop_state_t state_nxt;
   logic        coast_ok;

   assign coast_ok = (coast_speed_r != RST_ZERO) && (coast_speed_r < max_speed_i);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (setpoint == RST_ZERO && coast_ok) begin
               state_nxt = ST_DECEL;
            end
         end
         ST_DECEL: begin
            if (setpoint != RST_ZERO) begin
               state_nxt = ST_RUN;
            end else if (measured_speed_i <= coast_speed_r) begin
               state_nxt = ST_COAST;
            end
         end
         ST_COAST: begin
            if (setpoint != RST_ZERO) begin
               state_nxt = ST_RUN;
            end
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Drive commands
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         speed_target_o   <= RST_ZERO;
         coast_o          <= 1'b0;
         fan_stop_o       <= 1'b0;
         watchdog_alarm_o <= 1'b0;
         restart_o        <= 1'b0;
      end else begin
         fan_stop_o       <= wd_trip_r;
         watchdog_alarm_o <= wd_trip_r;
         restart_o        <= restart_cmd;
         coast_o          <= !wd_trip_r && state_nxt == ST_COAST;
         if (wd_trip_r || state_nxt == ST_COAST) begin
            speed_target_o <= RST_ZERO;
         end else if (state_nxt == ST_DECEL) begin
            speed_target_o <= coast_speed_r;
         end else begin
            speed_target_o <= skipped;
         end
      end
   end

   // Configuration outputs
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_limit_o <= RST_POWER;
         mode_o        <= RST_ZERO[3:0];
         loop_cfg_o    <= '0;
         link_cfg_o    <= '0;
      end else begin
         power_limit_o        <= power_r;
         mode_o               <= mode_r[3:0];
         loop_cfg_o.enable    <= loop_on;
         loop_cfg_o.invert    <= polarity_r[0];
         loop_cfg_o.reference <= loop_ref;
         loop_cfg_o.kp        <= kp_r;
         loop_cfg_o.ki        <= ki_r;
         loop_cfg_o.kd        <= kd_r;
         loop_cfg_o.period_ms <= period_r;
         link_cfg_o.station   <= active_station_r;
         link_cfg_o.bit_rate  <= bit_rate_r;
         link_cfg_o.framing   <= active_framing_r;
      end
   end

   // Digital output function
   logic thr_on;

   assign thr_on = speed_high_r != RST_ZERO;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         digital_out_o <= 1'b0;
      end else begin
         case (dout_func_r[1:0])
            DOUT_TACHO:  digital_out_o <= tacho_pwm_i;
            DOUT_ALARM:  digital_out_o <= alarm_i || wd_trip_r;
            DOUT_THRESH: digital_out_o <= thr_on && (measured_speed_i > speed_high_r);
            DOUT_WINDOW: digital_out_o <= thr_on && (measured_speed_i >= speed_low_i) &&
                                          (measured_speed_i <= speed_high_r);
            default:     digital_out_o <= 1'b0;
         endcase
      end
   end

endmodule // fan_cfg_bank

/* File: hw/fan_cfg_pkg.sv */
// Constants, register map and carrier types of the fan drive configuration bank.
// Assumes a 200 MHz core clock and 16-bit holding registers.
package fan_cfg_pkg;

   // Clock and time
   localparam int unsigned CLK_FREQ_HZ    = 200_000_000;
   localparam int unsigned WD_UNIT_S      = 1;
   localparam int unsigned SEC_CYCLES_DEF = CLK_FREQ_HZ * WD_UNIT_S;

   // Holding register indices
   localparam logic [7:0] REG_RESTART     = 8'h00;
   localparam logic [7:0] REG_POLARITY    = 8'h1f;
   localparam logic [7:0] REG_SKIP_START  = 8'h20;
   localparam logic [7:0] REG_SKIP_END    = 8'h21;
   localparam logic [7:0] REG_MODE        = 8'h22;
   localparam logic [7:0] REG_COAST_SPEED = 8'h23;
   localparam logic [7:0] REG_POWER_LIMIT = 8'h24;
   localparam logic [7:0] REG_STATION     = 8'h2d;
   localparam logic [7:0] REG_DOUT_FUNC   = 8'h2e;
   localparam logic [7:0] REG_BIT_RATE    = 8'h2f;
   localparam logic [7:0] REG_FRAMING     = 8'h30;
   localparam logic [7:0] REG_LOOP_REF    = 8'h32;
   localparam logic [7:0] REG_KP          = 8'h33;
   localparam logic [7:0] REG_KI          = 8'h34;
   localparam logic [7:0] REG_KD          = 8'h35;
   localparam logic [7:0] REG_PERIOD      = 8'h36;
   localparam logic [7:0] REG_SPEED_HIGH  = 8'h37;
   localparam logic [7:0] REG_WATCHDOG    = 8'h38;
   localparam logic [7:0] REG_TEMP_SET    = 8'h42;

   // Reset values
   localparam logic [15:0] RST_ZERO       = 16'h0000;
   localparam logic [15:0] RST_SKIP       = 16'h4e20;
   localparam logic [15:0] RST_POWER      = 16'h0546;
   localparam logic [15:0] RST_STATION    = 16'h0001;
   localparam logic [15:0] RST_BIT_RATE   = 16'h00c0;

   // Accepted value limits
   localparam logic [15:0] MAX_POLARITY   = 16'h0001;
   localparam logic [15:0] MAX_MODE       = 16'h000c;
   localparam logic [15:0] MIN_POWER      = 16'h000a;
   localparam logic [15:0] MAX_POWER      = 16'h0546;
   localparam logic [15:0] MIN_STATION    = 16'h0001;
   localparam logic [15:0] MAX_STATION    = 16'h00f7;
   localparam logic [15:0] MAX_DOUT_FUNC  = 16'h0003;
   localparam logic [15:0] BIT_RATE_9K6   = 16'h0060;
   localparam logic [15:0] BIT_RATE_19K2  = 16'h00c0;
   localparam logic [15:0] MAX_FRAMING    = 16'h0002;
   localparam logic [15:0] MAX_LOOP_REF   = 16'h0064;
   localparam logic [15:0] MAX_GAIN       = 16'h7fff;
   localparam logic [15:0] RESTART_CMD    = 16'h0001;

   // Operating modes
   localparam logic [3:0] MODE_BUS_SPEED   = 4'h0;
   localparam logic [3:0] MODE_ANA_SPEED   = 4'h1;
   localparam logic [3:0] MODE_FIX_SPEED   = 4'h2;
   localparam logic [3:0] MODE_FOLLOWER    = 4'h3;
   localparam logic [3:0] MODE_ANA_AIR     = 4'h4;
   localparam logic [3:0] MODE_TMP_AIR     = 4'h5;
   localparam logic [3:0] MODE_FIX_AIR     = 4'h6;
   localparam logic [3:0] MODE_ANA_EMUL    = 4'h7;
   localparam logic [3:0] MODE_TMP_EMUL    = 4'h8;
   localparam logic [3:0] MODE_FIX_EMUL    = 4'h9;
   localparam logic [3:0] MODE_LOOP_ANA    = 4'ha;
   localparam logic [3:0] MODE_LOOP_TMP    = 4'hb;
   localparam logic [3:0] MODE_LOOP_FIX    = 4'hc;

   // Digital output functions
   localparam logic [1:0] DOUT_TACHO  = 2'h0;
   localparam logic [1:0] DOUT_ALARM  = 2'h1;
   localparam logic [1:0] DOUT_THRESH = 2'h2;
   localparam logic [1:0] DOUT_WINDOW = 2'h3;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_DECEL = 2'b01,
      ST_COAST = 2'b10
   } stop_state_t;

   // Register request from the frame decoder
   typedef struct packed {
      logic        frame_ok;
      logic [7:0]  station;
      logic        wr;
      logic        rd;
      logic [7:0]  index;
      logic [15:0] wdata;
   } reg_req_t;

   // Register answer to the frame encoder
   typedef struct packed {
      logic        ack;
      logic        exc;
      logic [15:0] rdata;
   } reg_rsp_t;

   // Closed-loop controller settings
   typedef struct packed {
      logic        enable;
      logic        invert;
      logic [15:0] reference;
      logic [15:0] kp;
      logic [15:0] ki;
      logic [15:0] kd;
      logic [15:0] period_ms;
   } loop_cfg_t;

   // Serial port settings
   typedef struct packed {
      logic [7:0]  station;
      logic [15:0] bit_rate;
      logic [1:0]  framing;
   } link_cfg_t;

endpackage
